// [hdl/counter_array_pkg.sv]
// Shared constants for the counter array timebase and interrupt block
package counter_array_pkg;

  // ==========================================================
  // Widths
  localparam int ADDR_W       = 8;
  localparam int DATA_W       = 32;
  localparam int CNT_W        = 16;
  localparam int NUM_CHANNELS = 5;

  // ==========================================================
  // Register byte offsets on the Wishbone bus
  localparam logic [7:0] OFS_CNT_LO = 8'h00;  // counter_low_byte
  localparam logic [7:0] OFS_CNT_HI = 8'h04;  // counter_high_byte
  localparam logic [7:0] OFS_MODE   = 8'h08;  // array_mode_reg
  localparam logic [7:0] OFS_FLAGS  = 8'h0C;  // intermediate and channel flags
  localparam logic [7:0] OFS_IRQ_EN = 8'h10;  // enables and cycle length

  // ==========================================================
  // array_mode_reg fields
  localparam int MODE_OVF_IRQ_EN_BIT = 0;
  localparam int MODE_TB_LSB         = 1;
  localparam int MODE_WDT_EN_BIT     = 6;
  localparam int MODE_IDLE_STOP_BIT  = 7;
  localparam int MODE_OVF_FLAG_BIT   = 8;

  // Flags register fields
  localparam int FLAG_INTER_BIT = 0;
  localparam int FLAG_CHAN_LSB  = 1;

  // Enable register fields
  localparam int IEN_INTER_BIT = 0;
  localparam int IEN_CHAN_LSB  = 1;
  localparam int IEN_CLSEL_LSB = 8;
  localparam int IEN_ARRAY_BIT = 10;

  // ==========================================================
  // Reset values
  localparam logic [CNT_W-1:0] RST_COUNT     = 16'h0000;
  localparam logic [2:0]       RST_TIMEBASE  = 3'h0;
  localparam logic             RST_WDT_EN    = 1'b1;
  localparam logic [1:0]       RST_CLSEL     = 2'h0;

  // ==========================================================
  // Timebase select codes; 6 and 7 are reserved
  localparam logic [2:0] TB_SYS_DIV12 = 3'h0;
  localparam logic [2:0] TB_SYS_DIV4  = 3'h1;
  localparam logic [2:0] TB_TIMER0    = 3'h2;
  localparam logic [2:0] TB_EXT_FALL  = 3'h3;
  localparam logic [2:0] TB_SYS       = 3'h4;
  localparam logic [2:0] TB_OSC_DIV8  = 3'h5;

  // Prescaler terminal counts (divide by 12 and by 4)
  localparam logic [3:0] DIV12_LAST = 4'hB;
  localparam logic [1:0] DIV4_LAST  = 2'h3;

endpackage

// [hdl/counter_array_timebase_irq.sv]
// Shared counter of the counter array with timebase, snapshot and interrupts
//
// Design decisions made here: the register offsets and the Wishbone interface to the registers.
`timescale 1ns/1ps
module counter_array_timebase_irq
  import counter_array_pkg::*;
(
  input  wire logic                                clk_i,                   // System clock
  input  wire logic                                rst_i,                   // Synchronous reset
  input  wire logic                                cyc_i,                   // Wishbone cycle
  input  wire logic                                stb_i,                   // Wishbone strobe
  input  wire logic                                we_i,                    // Wishbone write
  input  wire logic [counter_array_pkg::ADDR_W-1:0] adr_i,                  // Byte address
  input  wire logic [3:0]                          sel_i,                   // Byte lanes
  input  wire logic [counter_array_pkg::DATA_W-1:0] dat_i,                  // Write data
  output logic      [counter_array_pkg::DATA_W-1:0] dat_o,                  // Read data
  output logic                                     ack_o,                   // Wishbone ack
  input  wire logic                                timer0_overflow_i,       // Timer 0 overflow pulse
  input  wire logic                                external_count_input_i,  // Count pin
  input  wire logic                                ext_osc_div8_i,          // Oscillator over 8
  input  wire logic                                cpu_idle_i,              // Core is in Idle
  input  wire logic                                global_irq_enable_i,     // Core global enable
  input  wire logic [counter_array_pkg::NUM_CHANNELS-1:0] channel_event_i,  // Channel trigger pulses
  output logic      [counter_array_pkg::CNT_W-1:0] counter_o,               // Shared count to channels
  output logic                                     array_irq_o,             // Enabled flag OR
  output logic                                     irq_request_o,           // Request seen by core
  output logic                                     watchdog_enable_o        // Module 4 watchdog on
);

  // ==========================================================
  // Declarations
  logic [CNT_W-1:0]        count;
  logic [7:0]              snapshot;
  logic [2:0]              timebase_select;
  logic                    counter_overflow_irq_en;
  logic                    idle_stop_ctrl;
  logic                    wdt_en;
  logic                    counter_overflow_flag;
  logic                    intermediate_overflow_flag;
  logic                    intermediate_overflow_irq_en;
  logic [NUM_CHANNELS-1:0] channel_event_flag;
  logic [NUM_CHANNELS-1:0] channel_event_irq_en;
  logic [1:0]              cycle_length_select;
  logic                    array_irq_enable;
  logic                    tick;
  logic                    advance;
  logic                    wrap;
  logic                    inter_wrap;
  logic                    low_ones;
  logic                    req;
  logic                    wr;
  logic                    rd;
  logic                    wr_lo;
  logic                    wr_hi;
  logic                    wr_mode;
  logic                    wr_flags;
  logic                    wr_ien;
  logic                    clr_ovf;
  logic                    clr_inter;
  logic                    any_pending;
  logic [DATA_W-1:0]       next_dat;
  logic [CNT_W-1:0]        next_count;

  // ==========================================================
  // Timebase: all sources arrive here as one-cycle enables
  // at most one count step per clock
  timebase_gen timebase_gen_inst (
    .clk_i                  (clk_i),
    .rst_i                  (rst_i),
    .timebase_select_i      (timebase_select),
    .timer0_overflow_i      (timer0_overflow_i),
    .external_count_input_i (external_count_input_i),
    .ext_osc_div8_i         (ext_osc_div8_i),
    .tick_o                 (tick)
  );

  // ==========================================================
  // Bus decode; the access is performed in the cycle before ack rises,
  // which keeps a request still held in the ack cycle from acting twice
  // Lane 0 carries the low control bits,
  // lane 1 the overflow clear, cycle length and array enable
  assign req      = cyc_i & stb_i & ~ack_o;
  assign wr       = req & we_i;
  assign rd       = req & ~we_i;
  assign wr_lo    = wr & (adr_i == OFS_CNT_LO) & sel_i[0];
  assign wr_hi    = wr & (adr_i == OFS_CNT_HI) & sel_i[0];
  assign wr_mode  = wr & (adr_i == OFS_MODE);
  assign wr_flags = wr & (adr_i == OFS_FLAGS) & sel_i[0];
  assign wr_ien   = wr & (adr_i == OFS_IRQ_EN);

  // Write-one-to-clear on the sticky flags
  assign clr_ovf   = wr_mode & sel_i[1] & dat_i[MODE_OVF_FLAG_BIT];
  assign clr_inter = wr_flags & dat_i[FLAG_INTER_BIT];

  // ==========================================================
  // Advance decision; Idle only stops the count when asked to,
  // the reserved codes never produce a tick at all
  // and so leave the count frozen;
  // Idle alone never stops it
  assign advance = tick & ~(idle_stop_ctrl & cpu_idle_i);

  // Full wrap from all ones
  assign wrap = advance & (count == 16'hFFFF);

  // Intermediate wrap point follows the cycle length field
  // Codes 0 to 3 wrap out of bits
  // 7 to 10 of the count
  always_comb begin
    case (cycle_length_select)
      2'h0:    low_ones = &count[7:0];
      2'h1:    low_ones = &count[8:0];
      2'h2:    low_ones = &count[9:0];
      default: low_ones = &count[10:0];
    endcase
  end
  assign inter_wrap = advance & low_ones;

  // ==========================================================
  // Counter; a software load of either byte wins over a tick
  // in the same cycle, reads have no path into this process
  always_comb begin
    next_count = count;
    if (wr_lo) begin
      next_count[7:0] = dat_i[7:0];
    end else if (wr_hi) begin
      next_count[15:8] = dat_i[7:0];
    end else if (advance) begin
      next_count = count + 16'h0001;
    end
  end

  // Count register; only reset overrides the next value
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count <= RST_COUNT;
    end else begin
      count <= next_count;
    end
  end

  // Shared count for the five capture/compare channels
  // One clock behind the internal count,
  // so channels see each value late
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      counter_o <= RST_COUNT;
    end else begin
      counter_o <= count;
    end
  end

  // ==========================================================
  // Snapshot of the high byte, taken from the same counter value
  // that the low byte read returns, so the pair is coherent
  // A lone high byte read returns the
  // last snapshot, possibly stale
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      snapshot <= 8'h00;
    end else if (rd && adr_i == OFS_CNT_LO) begin
      snapshot <= count[15:8];
    end
  end

  // ==========================================================
  // Mode register; while the watchdog is on only its own enable
  // bit and the overflow flag clear take writes, so a runaway program cannot retime the
  // counter under the watchdog
  // Clear the watchdog bit first, then
  // the other mode bits take writes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      timebase_select         <= RST_TIMEBASE;
      counter_overflow_irq_en <= 1'b0;
      idle_stop_ctrl          <= 1'b0;
      wdt_en                  <= RST_WDT_EN;
    end else if (wr_mode && sel_i[0]) begin
      wdt_en <= dat_i[MODE_WDT_EN_BIT];
      if (!wdt_en) begin
        timebase_select         <= dat_i[MODE_TB_LSB +: 3];
        counter_overflow_irq_en <= dat_i[MODE_OVF_IRQ_EN_BIT];
        idle_stop_ctrl          <= dat_i[MODE_IDLE_STOP_BIT];
      end
    end
  end

  // Watchdog state for module 4, held in
  // a flop so the port never glitches
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      watchdog_enable_o <= RST_WDT_EN;
    end else begin
      watchdog_enable_o <= wdt_en;
    end
  end

  // ==========================================================
  // Enable register: per-source enables, cycle length, array enable
  // One cycle length serves every
  // channel in an 8 to 11 bit cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      intermediate_overflow_irq_en <= 1'b0;
      channel_event_irq_en         <= '0;
      cycle_length_select          <= RST_CLSEL;
      array_irq_enable             <= 1'b0;
    end else if (wr_ien) begin
      if (sel_i[0]) begin
        intermediate_overflow_irq_en <= dat_i[IEN_INTER_BIT];
        channel_event_irq_en         <= dat_i[IEN_CHAN_LSB +: NUM_CHANNELS];
      end
      if (sel_i[1]) begin
        cycle_length_select <= dat_i[IEN_CLSEL_LSB +: 2];
        array_irq_enable    <= dat_i[IEN_ARRAY_BIT];
      end
    end
  end

  // ==========================================================
  // Sticky flags: set regardless of enables, and a set in the
  // same cycle as a clear wins so no event is lost
  // Software clears a flag by writing
  // a one to its bit
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      counter_overflow_flag <= 1'b0;
    end else begin
      counter_overflow_flag <= (counter_overflow_flag & ~clr_ovf) | wrap;
    end
  end

  // Intermediate flag; same rule, a
  // wrap beats a clear in one cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      intermediate_overflow_flag <= 1'b0;
    end else begin
      intermediate_overflow_flag <= (intermediate_overflow_flag & ~clr_inter) | inter_wrap;
    end
  end

  // One flag per channel, set by that channel's mode logic
  // outside; a held event keeps it set
  generate
    for (genvar ch = 0; ch < NUM_CHANNELS; ch++) begin : g_chan
      logic clr_ch;
      assign clr_ch = wr_flags & dat_i[FLAG_CHAN_LSB + ch];
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          channel_event_flag[ch] <= 1'b0;
        end else begin
          channel_event_flag[ch] <= (channel_event_flag[ch] & ~clr_ch) | channel_event_i[ch];
        end
      end
    end
  endgenerate

  // ==========================================================
  // Interrupt tree; one cycle behind the flags, which costs a
  // clock of latency but keeps both outputs glitch free
  // Flags outlive the request, so the
  // handler clears the source first
  assign any_pending = (counter_overflow_flag & counter_overflow_irq_en)
                     | (intermediate_overflow_flag & intermediate_overflow_irq_en)
                     | (|(channel_event_flag & channel_event_irq_en));

  // Both requests leave from flops:
  // no decode glitch reaches the core
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      array_irq_o   <= 1'b0;
      irq_request_o <= 1'b0;
    end else begin
      array_irq_o   <= any_pending;
      irq_request_o <= any_pending & array_irq_enable & global_irq_enable_i;
    end
  end

  // ==========================================================
  // Read mux; unmapped addresses read as zero and still ack
  // Only a low byte read has a side
  // effect: it loads the snapshot
  always_comb begin
    next_dat = '0;
    if (adr_i == OFS_CNT_LO) begin
      next_dat[7:0] = count[7:0];
    end else if (adr_i == OFS_CNT_HI) begin
      next_dat[7:0] = snapshot;
    end else if (adr_i == OFS_MODE) begin
      next_dat[MODE_OVF_IRQ_EN_BIT]   = counter_overflow_irq_en;
      next_dat[MODE_TB_LSB +: 3]      = timebase_select;
      next_dat[MODE_WDT_EN_BIT]       = wdt_en;
      next_dat[MODE_IDLE_STOP_BIT]    = idle_stop_ctrl;
      next_dat[MODE_OVF_FLAG_BIT]     = counter_overflow_flag;
    end else if (adr_i == OFS_FLAGS) begin
      next_dat[FLAG_INTER_BIT]              = intermediate_overflow_flag;
      next_dat[FLAG_CHAN_LSB +: NUM_CHANNELS] = channel_event_flag;
    end else if (adr_i == OFS_IRQ_EN) begin
      next_dat[IEN_INTER_BIT]               = intermediate_overflow_irq_en;
      next_dat[IEN_CHAN_LSB +: NUM_CHANNELS] = channel_event_irq_en;
      next_dat[IEN_CLSEL_LSB +: 2]          = cycle_length_select;
      next_dat[IEN_ARRAY_BIT]               = array_irq_enable;
    end
  end

  // ==========================================================
  // Ack one cycle after the request, dropped the cycle after;
  // a stb still high in the ack cycle gets no second access
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
    end else begin
      ack_o <= req;
    end
  end

  // Read data stands only in the ack cycle
  // and is zero otherwise
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= '0;
    end else begin
      dat_o <= rd ? next_dat : '0;
    end
  end

endmodule

// [hdl/timebase_gen.sv]
// Timebase selector: turns every count source into a one-cycle tick
`timescale 1ns/1ps
module timebase_gen
  import counter_array_pkg::*;
(
  input  wire logic       clk_i,                   // System clock
  input  wire logic       rst_i,                   // Synchronous reset
  input  wire logic [2:0] timebase_select_i,       // Source code
  input  wire logic       timer0_overflow_i,       // Timer 0 overflow pulse
  input  wire logic       external_count_input_i,  // Count pin, asynchronous
  input  wire logic       ext_osc_div8_i,          // Oscillator over 8, asynchronous
  output logic            tick_o                   // One-cycle count enable
);

  logic [3:0] div12;
  logic [1:0] div4;
  logic       cnt_s1, cnt_s2, cnt_s3;
  logic       osc_s1, osc_s2, osc_s3;

  // ==========================================================
  // Free running prescalers; they never stop, so a source switch
  // may give a shortened first period
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div12 <= 4'h0;
      div4  <= 2'h0;
    end else begin
      div12 <= (div12 == DIV12_LAST) ? 4'h0 : div12 + 4'h1;
      div4  <= div4 + 2'h1;
    end
  end

  // ==========================================================
  // Two-stage synchronisers plus a history stage; only stage two
  // and three feed the edge detectors
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_s1 <= 1'b1;
      cnt_s2 <= 1'b1;
      cnt_s3 <= 1'b1;
      osc_s1 <= 1'b0;
      osc_s2 <= 1'b0;
      osc_s3 <= 1'b0;
    end else begin
      cnt_s1 <= external_count_input_i;
      cnt_s2 <= cnt_s1;
      cnt_s3 <= cnt_s2;
      osc_s1 <= ext_osc_div8_i;
      osc_s2 <= osc_s1;
      osc_s3 <= osc_s2;
    end
  end

  // ==========================================================
  // Source select; falling edges closer than four clocks can be
  // missed, so the pin source is limited to a quarter of the clock
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tick_o <= 1'b0;
    end else begin
      case (timebase_select_i)
        TB_SYS_DIV12: tick_o <= (div12 == DIV12_LAST);
        TB_SYS_DIV4:  tick_o <= (div4 == DIV4_LAST);
        TB_TIMER0:    tick_o <= timer0_overflow_i;
        TB_EXT_FALL:  tick_o <= cnt_s3 & ~cnt_s2;
        TB_SYS:       tick_o <= 1'b1;
        TB_OSC_DIV8:  tick_o <= ~osc_s3 & osc_s2;
        default:      tick_o <= 1'b0;
      endcase
    end
  end

endmodule

// [verif/counter_array_props.sv]
// Port checker for the counter array timebase and interrupt block
`timescale 1ns/1ps
module counter_array_props
  import counter_array_pkg::*;
(
  input wire logic                                  clk_i,               // Clock
  input wire logic                                  rst_i,               // Reset
  input wire logic                                  cyc_i,               // Cycle
  input wire logic                                  stb_i,               // Strobe
  input wire logic                                  we_i,                // Write
  input wire logic [counter_array_pkg::ADDR_W-1:0]  adr_i,               // Address
  input wire logic [counter_array_pkg::DATA_W-1:0]  dat_o,               // Read data
  input wire logic                                  ack_o,               // Ack
  input wire logic                                  global_irq_enable_i, // Global enable
  input wire logic [counter_array_pkg::CNT_W-1:0]   counter_o,           // Count
  input wire logic                                  array_irq_o,         // Array request
  input wire logic                                  irq_request_o,       // Core request
  input wire logic                                  watchdog_enable_o    // Watchdog on
);
  import counter_array_pkg::*;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // ======
  // Bus handshake
  a_ack_pulse: assert property (ack_o |=> !ack_o) else $error("ack held two cycles");
  a_ack_answer: assert property (cyc_i && stb_i && !ack_o |=> ack_o) else $error("request not answered");
  a_dat_idle: assert property (!ack_o |-> dat_o == '0) else $error("read data outside ack");
  a_byte_read: assert property (
    ack_o && !we_i && (adr_i == OFS_CNT_LO || adr_i == OFS_CNT_HI) |-> dat_o[31:8] == 24'h00_0000)
    else $error("counter byte read wider than a byte");

  // ======
  // Counting: only loads may jump, otherwise one step at a time
  a_count_step: assert property (
    counter_o != $past(counter_o) && !$past(cyc_i && we_i) && !$past(cyc_i && we_i, 2)
    |-> counter_o == $past(counter_o) + 16'h0001) else $error("counter jumped");

  // ======
  // Interrupt gating
  a_irq_global: assert property (irq_request_o |-> $past(global_irq_enable_i))
    else $error("request without global enable");
  a_irq_source: assert property (irq_request_o |-> array_irq_o || $past(array_irq_o))
    else $error("request without enabled flag");

  // ======
  // Reset state and watchdog lock
  a_wdt_reset: assert property (
    $past(rst_i) |-> watchdog_enable_o && counter_o == 16'h0000 && !array_irq_o)
    else $error("wrong state after reset");
  a_wdt_write: assert property ($changed(watchdog_enable_o) |-> $past(ack_o && we_i))
    else $error("watchdog enable changed without a write");

  c_wrap: cover property ($past(counter_o) == 16'hFFFF && counter_o == 16'h0000);
  c_irq: cover property (irq_request_o);
  c_read: cover property (ack_o && !we_i);
endmodule

// [verif/counter_array_timebase_irq_tb.sv]
// Bench for the counter array block: bus tasks and directed sequences
`timescale 1ns/1ps
module counter_array_timebase_irq_tb;
  import counter_array_pkg::*;
  logic        clk_i, rst_i, cyc_i, stb_i, we_i, timer0_overflow_i, cpu_idle_i, global_irq_enable_i;
  logic        ack_o, array_irq_o, irq_request_o, watchdog_enable_o, pin, osc;
  logic [7:0]  adr_i, b;
  logic [3:0]  sel_i;
  logic [31:0] dat_i, dat_o, q, q2;
  logic [4:0]  channel_event_i;
  logic [15:0] counter_o, v;
  logic [2:0]  t0_phase = 3'h0;
  int          mismatches, checks;
  logic [7:0]  mode_t [10] = '{8'h00, 8'h02, 8'h04, 8'h06, 8'h08, 8'h0A, 8'h0C, 8'h0E, 8'h08, 8'h88};
  logic [15:0] cnt_t [10] = '{16'h0004, 16'h000C, 16'h0006, 16'h0006, 16'h0030, 16'h0003, 16'h0000,
                              16'h0000, 16'h0030, 16'h0000};

  always #10 clk_i = ~clk_i;
  // Timer 0 overflow pulse every eighth clock
  always @(posedge clk_i) begin
    t0_phase <= t0_phase + 3'h1;
    timer0_overflow_i <= (t0_phase == 3'h7);
  end

  counter_array_timebase_irq counter_array_timebase_irq_inst (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .timer0_overflow_i(timer0_overflow_i), .external_count_input_i(pin), .ext_osc_div8_i(osc),
    .cpu_idle_i(cpu_idle_i), .global_irq_enable_i(global_irq_enable_i), .channel_event_i(channel_event_i),
    .counter_o(counter_o), .array_irq_o(array_irq_o), .irq_request_o(irq_request_o),
    .watchdog_enable_o(watchdog_enable_o));
  far_side_sources far_side_sources_inst (.clk_i(clk_i), .rst_i(rst_i), .pin_o(pin), .osc_o(osc));

  // ======
  // Compare, bus access and verdict
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Classic cycle: request held until ack is sampled, then released
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    do begin
      @(posedge clk_i);
    end while (ack_o !== 1'b1);
    r = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0000_0000, q);
    chk(q, e);
  endtask
  // Counts gained over 48 clocks, after the new source has settled
  task automatic rate(input logic [7:0] m, input logic [15:0] e);
    logic [15:0] c0;
    wr(OFS_MODE, {24'h00_0000, m});
    repeat (8) @(posedge clk_i);
    c0 = counter_o;
    repeat (48) @(posedge clk_i);
    c0 = counter_o - c0;
    chk(32'(c0), 32'(e));
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Watchdog: the whole sequence needs only about 1100 clocks
  initial begin
    #400000;
    mismatches++;
    conclude();
  end

  // ======
  // Main sequence
  initial begin
    clk_i = 1'b0;
    rst_i = 1'b1;
    {cyc_i, stb_i, we_i, cpu_idle_i, global_irq_enable_i} = 5'h00;
    {adr_i, dat_i, channel_event_i} = '0;
    sel_i = 4'hF;
    mismatches = 0;
    checks = 0;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(OFS_MODE, 32'h0000_0040);
    chk(32'(watchdog_enable_o), 32'h0000_0001);
    rd(OFS_CNT_HI, 32'h0000_0000);
    rd(8'h20, 32'h0000_0000);
    wr(OFS_MODE, 32'h0000_004A);
    rd(OFS_MODE, 32'h0000_0040);
    wr(OFS_MODE, 32'h0000_0000);
    rd(OFS_MODE, 32'h0000_0000);
    chk(32'(watchdog_enable_o), 32'h0000_0000);
    // Every timebase code, then Idle with and without the stop bit
    for (int i = 0; i < 10; i++) begin
      cpu_idle_i <= (i >= 8);
      rate(mode_t[i], cnt_t[i]);
    end
    cpu_idle_i <= 1'b0;
    // Two low reads while counting every clock are three clocks apart
    bus(1'b0, OFS_CNT_LO, 32'h0000_0000, q);
    bus(1'b0, OFS_CNT_LO, 32'h0000_0000, q2);
    b = q2[7:0] - q[7:0];
    chk(32'(b), 32'h0000_0003);
    // Snapshot stays put while the live high byte changes
    wr(OFS_MODE, 32'h0000_000C);
    wr(OFS_CNT_HI, 32'h0000_0012);
    wr(OFS_CNT_LO, 32'h0000_00FF);
    rd(OFS_CNT_LO, 32'h0000_00FF);
    wr(OFS_CNT_HI, 32'h0000_0034);
    rd(OFS_CNT_HI, 32'h0000_0012);
    rd(OFS_CNT_LO, 32'h0000_00FF);
    rd(OFS_CNT_HI, 32'h0000_0034);
    // Intermediate flag for each cycle length, just below the chosen bit and one byte lower
    for (int k = 0; k < 4; k++) begin
      for (int j = 0; j < 2; j++) begin
        v = (16'h0100 << k) - (j == 1 ? 16'h0104 : 16'h0004);
        wr(OFS_MODE, 32'h0000_000C);
        wr(OFS_CNT_LO, {24'h00_0000, v[7:0]});
        wr(OFS_CNT_HI, {24'h00_0000, v[15:8]});
        wr(OFS_FLAGS, 32'h0000_003F);
        wr(OFS_IRQ_EN, {22'h00_0000, 2'(k), 8'h00});
        wr(OFS_MODE, 32'h0000_0008);
        repeat (10) @(posedge clk_i);
        rd(OFS_FLAGS, (j == 0 || k == 0) ? 32'h0000_0001 : 32'h0000_0000);
      end
    end
    // Channel flags, each from its own event, with enables off
    wr(OFS_MODE, 32'h0000_010C);
    for (int i = 0; i < 5; i++) begin
      wr(OFS_FLAGS, 32'h0000_003F);
      channel_event_i <= 5'(1 << i);
      @(posedge clk_i);
      channel_event_i <= 5'h00;
      rd(OFS_FLAGS, 32'h0000_0002 << i);
    end
    wr(OFS_IRQ_EN, 32'h0000_001F);
    repeat (2) @(posedge clk_i);
    chk(32'(array_irq_o), 32'h0000_0000);
    // Full overflow, then interrupt gating and software clear
    wr(OFS_CNT_LO, 32'h0000_00F0);
    wr(OFS_CNT_HI, 32'h0000_00FF);
    wr(OFS_FLAGS, 32'h0000_003F);
    wr(OFS_IRQ_EN, 32'h0000_0000);
    wr(OFS_MODE, 32'h0000_0008);
    repeat (30) @(posedge clk_i);
    rd(OFS_MODE, 32'h0000_0108);
    chk(32'(array_irq_o), 32'h0000_0000);
    wr(OFS_MODE, 32'h0000_0009);
    repeat (2) @(posedge clk_i);
    chk(32'(array_irq_o), 32'h0000_0001);
    wr(OFS_IRQ_EN, 32'h0000_0400);
    repeat (2) @(posedge clk_i);
    chk(32'(irq_request_o), 32'h0000_0000);
    global_irq_enable_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    chk(32'(irq_request_o), 32'h0000_0001);
    repeat (100) @(posedge clk_i);
    rd(OFS_MODE, 32'h0000_0109);
    wr(OFS_MODE, 32'h0000_0109);
    repeat (3) @(posedge clk_i);
    chk(32'(array_irq_o), 32'h0000_0000);
    chk(32'(irq_request_o), 32'h0000_0000);
    conclude();
  end
endmodule

bind counter_array_timebase_irq counter_array_props counter_array_props_inst (.clk_i(clk_i), .rst_i(rst_i),
  .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .dat_o(dat_o), .ack_o(ack_o),
  .global_irq_enable_i(global_irq_enable_i), .counter_o(counter_o), .array_irq_o(array_irq_o),
  .irq_request_o(irq_request_o), .watchdog_enable_o(watchdog_enable_o));

// [verif/far_side_sources.sv]
// Far-side count sources: external count pin and oscillator over eight
`timescale 1ns/1ps
module far_side_sources (
  input  wire logic clk_i, // System clock
  input  wire logic rst_i, // Reset
  output logic      pin_o, // Count pin
  output logic      osc_o  // Oscillator over eight
);
  logic [3:0] phase;
  // One free-running phase paces both sources so counts per window are exact
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      phase <= 4'h0;
    end else begin
      phase <= phase + 4'h1;
    end
  end
  // Four clocks high, four low: falling edges never closer than four clocks
  assign pin_o = phase[2];
  // Oscillator runs free, one rising edge every sixteen clocks
  assign osc_o = phase[3];
endmodule
